//--- ies_pkg.sv
// Shared constants and types of the instruction execute subset.
// Assumes a single system clock and a classic Wishbone register bus.
`default_nettype none

package ies_pkg;

    // Register byte addresses on the Wishbone bus
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ACC    = 8'h04;
    localparam logic [7:0] REG_FLAGS  = 8'h08;
    localparam logic [7:0] REG_PC     = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PUSH   = 8'h14;
    localparam logic [7:0] REG_MADDR  = 8'h18;
    localparam logic [7:0] REG_MDATA  = 8'h1C;

    // Status register bit positions
    localparam int STS_BUSY  = 0;
    localparam int STS_SKIP  = 1;
    localparam int STS_TWO   = 2;
    localparam int STS_EMPTY = 3;
    localparam int STS_FULL  = 4;

    // Reset values and fixed data
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [7:0] MADDR_RST = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ONE  = 8'h01;
    localparam int DATA_AW = 8;

    typedef enum logic [4:0] {
        OP_NONE,
        OP_OR_INTO_MEMORY,
        OP_SUBROUTINE_EXIT,
        OP_SUBROUTINE_EXIT_VALUE,
        OP_INTERRUPT_EXIT,
        OP_ROTATE_LEFT_MEM,
        OP_ROTATE_LEFT_TO_ACC,
        OP_ROTATE_LEFT_CARRY_MEM,
        OP_ROTATE_LEFT_CARRY_TO_ACC,
        OP_ROTATE_RIGHT_MEM,
        OP_ROTATE_RIGHT_TO_ACC,
        OP_ROTATE_RIGHT_CARRY_MEM,
        OP_ROTATE_RIGHT_CARRY_TO_ACC,
        OP_SUBTRACT_BORROW_ACC,
        OP_SUBTRACT_BORROW_TO_MEM,
        OP_DECREMENT_SKIP_ZERO,
        OP_DECREMENT_SKIP_ZERO_TO_ACC,
        OP_SET_BYTE,
        OP_SET_BIT,
        OP_INCREMENT_SKIP_ZERO,
        OP_INCREMENT_SKIP_ZERO_TO_ACC,
        OP_SKIP_BIT_NONZERO
    } ies_op_e;

    typedef enum logic [1:0] {
        EX_IDLE,
        EX_FETCH,
        EX_EXEC,
        EX_DUMMY
    } ies_state_e;

    // Command word as written to the command register
    typedef struct packed {
        logic [7:0] imm;
        logic [7:0] addr;
        logic [2:0] bitIdx;
        ies_op_e    op;
    } ies_cmd_s;

    // Status flags plus global interrupt enable
    typedef struct packed {
        logic gie;
        logic ov;
        logic z;
        logic ac;
        logic c;
    } ies_flags_s;

endpackage

`default_nettype wire

//--- ies_data_ram.sv
// Byte-wide data memory with one write port and a registered read port.
// Assumes the owner never needs write-through on the read port.
`default_nettype none

module ies_data_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // Write port
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    // Read port
    input  wire logic [AW-1:0] rdAddr,
    output logic      [DW-1:0] rdData
);

    logic [DW-1:0] store [0:(1<<AW)-1];

    // Contents have no reset, like the real array
    always_ff @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= '0;
        end else begin
            rdData <= store[rdAddr];
        end
    end

endmodule

`default_nettype wire

//--- ies_return_stack.sv
// Return-address stack with a registered top entry.
// Assumes push and pop never arrive in the same cycle.
`default_nettype none

module ies_return_stack #(
    parameter int W     = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // Requests
    input  wire logic                       push,
    input  wire logic [W-1:0]               pushData,
    input  wire logic                       pop,
    // State
    output logic      [W-1:0]               top,
    output logic                            empty,
    output logic                            full,
    output logic      [$clog2(DEPTH+1)-1:0] depth
);

    localparam int DPW = $clog2(DEPTH+1);

    logic [W-1:0]   entry [0:DEPTH-1];
    logic [DPW-1:0] sp_r;

    assign empty = (sp_r == '0);
    assign full  = (sp_r == DPW'(DEPTH));
    assign depth = sp_r;

    // A push onto a full stack is dropped rather than corrupting entries
    always_ff @(posedge clk) begin
        if (push && !full) begin
            entry[sp_r[$clog2(DEPTH)-1:0]] <= pushData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sp_r <= '0;
            top  <= '0;
        end else if (push && !full) begin
            sp_r <= sp_r + DPW'(1);
            top  <= pushData;
        end else if (pop && !empty) begin
            sp_r <= sp_r - DPW'(1);
            top  <= (sp_r > DPW'(1)) ?
                    entry[sp_r[$clog2(DEPTH)-1:0] - 2'd2] : '0;
        end
    end

endmodule

`default_nettype wire

//--- ies_exec_unit.sv
// Execute unit for one group of 8-bit accumulator core instructions.
// Assumes a classic Wishbone master and one system clock.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`default_nettype none

module ies_exec_unit #(
    parameter int PC_W        = 12,
    parameter int STACK_DEPTH = 16
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [31:0]       dat_i,
    input  wire logic [3:0]        sel_i,
    output logic                   ack_o,
    output logic      [31:0]       dat_o,
    // Core side
    output ies_pkg::ies_flags_s    flagsOut,
    output logic      [PC_W-1:0]   pcOut,
    output logic                   busy
);
    import ies_pkg::*;

    localparam int SDW = $clog2(STACK_DEPTH+1);

    function automatic logic isZero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                              input logic [31:0] nu,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nu[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ies_state_e       state_r;
    ies_state_e       state_nxt;
    ies_cmd_s         cmd_r;
    ies_cmd_s         cmd_nxt;
    ies_flags_s       flags_r;
    ies_flags_s       flags_nxt;
    logic [7:0]       acc_r;
    logic [7:0]       acc_nxt;
    logic [PC_W-1:0]  pc_r;
    logic [PC_W-1:0]  pc_nxt;
    logic [7:0]       memAddr_r;
    logic [7:0]       memAddr_nxt;
    logic             skip_r;
    logic             twoCyc_r;
    logic             ack_r;
    logic             idleQ_r;
    logic [31:0]      datO_r;

    // Bus decode
    wire logic        req      = cyc_i & stb_i;
    wire logic        idle     = (state_r == EX_IDLE);
    wire logic        grant    = req & ~ack_r & idle & idleQ_r;
    wire logic        wrTake   = req & we_i & ack_r;
    wire logic        hitCmd   = (adr_i == REG_CMD);
    wire logic        hitAcc   = (adr_i == REG_ACC);
    wire logic        hitFlags = (adr_i == REG_FLAGS);
    wire logic        hitPc    = (adr_i == REG_PC);
    wire logic        hitSts   = (adr_i == REG_STATUS);
    wire logic        hitPush  = (adr_i == REG_PUSH);
    wire logic        hitMaddr = (adr_i == REG_MADDR);
    wire logic        hitMdata = (adr_i == REG_MDATA);
    wire logic        launch   = wrTake & hitCmd;

    // Stack and memory wiring
    logic [PC_W-1:0]  stackTop;
    logic             stackEmpty;
    logic             stackFull;
    logic [SDW-1:0]   stackDepth;
    logic [7:0]       memQ;
    logic             exPop;
    logic             exWrMem;
    wire logic        inExec   = (state_r == EX_EXEC);
    wire logic        busWrMem = wrTake & hitMdata & sel_i[0];
    wire logic        memWrEn  = busWrMem | (inExec & exWrMem);
    wire logic [7:0]  memRdAddr = idle ? memAddr_r : cmd_r.addr;
    wire logic [7:0]  memWrAddr = inExec ? cmd_r.addr : memAddr_r;

    // Datapath candidates, from the fetched byte, the accumulator, the carry and the bit index
    wire logic [7:0]  bitMask  = 8'(BYTE_ONE << cmd_r.bitIdx);
    wire logic [7:0]  rotL     = {memQ[6:0], memQ[7]};
    wire logic [7:0]  rotLc    = {memQ[6:0], flags_r.c};
    wire logic [7:0]  rotR     = {memQ[0], memQ[7:1]};
    wire logic [7:0]  rotRc    = {flags_r.c, memQ[7:1]};
    wire logic [7:0]  memDec   = memQ - BYTE_ONE;
    wire logic [7:0]  memInc   = memQ + BYTE_ONE;
    wire logic [7:0]  memOr    = acc_r | memQ;
    wire logic [8:0]  sbcSum   = {1'b0, acc_r} + {1'b0, ~memQ}
                               + 9'(flags_r.c);
    wire logic [4:0]  sbcLow   = {1'b0, acc_r[3:0]} + {1'b0, ~memQ[3:0]}
                               + 5'(flags_r.c);
    wire logic [7:0]  sbcSeven = {1'b0, acc_r[6:0]} + {1'b0, ~memQ[6:0]}
                               + 8'(flags_r.c);

    // Execute decode
    logic [7:0]       exRes;
    logic             exWrAcc;
    logic             exUpdZ;
    logic             exUpdC;
    logic             exCarry;
    logic             exArith;
    logic             exSkip;
    logic             exExit;
    logic             exGie;

    always_comb begin
        exRes   = memQ;
        exWrAcc = 1'b0;
        exWrMem = 1'b0;
        exUpdZ  = 1'b0;
        exUpdC  = 1'b0;
        exCarry = flags_r.c;
        exArith = 1'b0;
        exSkip  = 1'b0;
        exExit  = 1'b0;
        exPop   = 1'b0;
        exGie   = 1'b0;
        unique case (cmd_r.op)
            OP_NONE: begin
            end
            OP_OR_INTO_MEMORY: begin
                exRes   = memOr;
                exWrMem = 1'b1;
                exUpdZ  = 1'b1;
            end
            OP_SUBROUTINE_EXIT: begin
                exExit = 1'b1;
            end
            OP_SUBROUTINE_EXIT_VALUE: begin
                exExit  = 1'b1;
                exRes   = cmd_r.imm;
                exWrAcc = 1'b1;
            end
            OP_INTERRUPT_EXIT: begin
                exExit = 1'b1;
                exGie  = 1'b1;
            end
            OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_ACC: begin
                exRes   = rotL;
                exWrMem = (cmd_r.op == OP_ROTATE_LEFT_MEM);
                exWrAcc = ~exWrMem;
            end
            OP_ROTATE_LEFT_CARRY_MEM, OP_ROTATE_LEFT_CARRY_TO_ACC: begin
                exRes   = rotLc;
                exUpdC  = 1'b1;
                exCarry = memQ[7];
                exWrMem = (cmd_r.op == OP_ROTATE_LEFT_CARRY_MEM);
                exWrAcc = ~exWrMem;
            end
            OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_TO_ACC: begin
                exRes   = rotR;
                exWrMem = (cmd_r.op == OP_ROTATE_RIGHT_MEM);
                exWrAcc = ~exWrMem;
            end
            OP_ROTATE_RIGHT_CARRY_MEM, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                exRes   = rotRc;
                exUpdC  = 1'b1;
                exCarry = memQ[0];
                exWrMem = (cmd_r.op == OP_ROTATE_RIGHT_CARRY_MEM);
                exWrAcc = ~exWrMem;
            end
            OP_SUBTRACT_BORROW_ACC, OP_SUBTRACT_BORROW_TO_MEM: begin
                exRes   = sbcSum[7:0];
                exUpdZ  = 1'b1;
                exUpdC  = 1'b1;
                exCarry = sbcSum[8];
                exArith = 1'b1;
                exWrMem = (cmd_r.op == OP_SUBTRACT_BORROW_TO_MEM);
                exWrAcc = ~exWrMem;
            end
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
                exRes   = memDec;
                exSkip  = isZero(memDec);
                exWrMem = (cmd_r.op == OP_DECREMENT_SKIP_ZERO);
                exWrAcc = ~exWrMem;
            end
            OP_SET_BYTE: begin
                exRes   = BYTE_ONES;
                exWrMem = 1'b1;
            end
            OP_SET_BIT: begin
                exRes   = memQ | bitMask;
                exWrMem = 1'b1;
            end
            OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
                exRes   = memInc;
                exSkip  = isZero(memInc);
                exWrMem = (cmd_r.op == OP_INCREMENT_SKIP_ZERO);
                exWrAcc = ~exWrMem;
            end
            OP_SKIP_BIT_NONZERO: begin
                exSkip = |(memQ & bitMask);
            end
            // Unassigned command codes pass through fetch and execute as a no-op that steps the pc by one
            default: begin
            end
        endcase
        exPop = inExec & exExit;
    end

    // Sequencing: fetch, execute, optional dummy cycle
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            EX_IDLE: begin
                if (launch) begin
                    state_nxt = EX_FETCH;
                end
            end
            EX_FETCH: begin
                state_nxt = EX_EXEC;
            end
            EX_EXEC: begin
                state_nxt = (exSkip | exExit) ? EX_DUMMY : EX_IDLE;
            end
            EX_DUMMY: begin
                state_nxt = EX_IDLE;
            end
        endcase
    end

    // Architectural state next values
    always_comb begin
        acc_nxt     = acc_r;
        flags_nxt   = flags_r;
        pc_nxt      = pc_r;
        cmd_nxt     = cmd_r;
        memAddr_nxt = memAddr_r;
        if (inExec) begin
            if (exWrAcc) begin
                acc_nxt = exRes;
            end
            if (exUpdZ) begin
                flags_nxt.z = isZero(exRes);
            end
            if (exUpdC) begin
                flags_nxt.c = exCarry;
            end
            if (exArith) begin
                flags_nxt.ac = sbcLow[4];
                flags_nxt.ov = sbcSeven[7] ^ sbcSum[8];
            end
            if (exGie) begin
                flags_nxt.gie = 1'b1;
            end
            if (exExit) begin
                pc_nxt = stackTop;
            end else if (exSkip) begin
                pc_nxt = pc_r + PC_W'(2);
            end else begin
                pc_nxt = pc_r + PC_W'(1);
            end
        end else if (wrTake) begin
            if (hitCmd) begin
                cmd_nxt = ies_cmd_s'(24'(laneMerge(32'(cmd_r), dat_i,
                                                   sel_i)));
            end
            if (hitAcc) begin
                acc_nxt = 8'(laneMerge(32'(acc_r), dat_i, sel_i));
            end
            if (hitFlags) begin
                flags_nxt = ies_flags_s'(5'(laneMerge(32'(flags_r),
                                                      dat_i, sel_i)));
            end
            if (hitPc) begin
                pc_nxt = PC_W'(laneMerge(32'(pc_r), dat_i, sel_i));
            end
            if (hitMaddr) begin
                memAddr_nxt = 8'(laneMerge(32'(memAddr_r), dat_i, sel_i));
            end
        end
    end

    // Read data, sampled when the answer is granted
    logic [31:0] rdMux;
    logic [31:0] stsWord;
    assign stsWord = 32'({stackFull, stackEmpty, twoCyc_r, skip_r, ~idle});
    assign rdMux = hitCmd   ? 32'(cmd_r)     :
                   hitAcc   ? 32'(acc_r)     :
                   hitFlags ? 32'(flags_r)   :
                   hitPc    ? 32'(pc_r)      :
                   hitSts   ? stsWord        :
                   hitPush  ? 32'(stackDepth) :
                   hitMaddr ? 32'(memAddr_r) :
                   hitMdata ? 32'(memQ)      : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= EX_IDLE;
            cmd_r     <= '0;
            acc_r     <= ACC_RST;
            flags_r   <= ies_flags_s'(FLAGS_RST);
            pc_r      <= '0;
            memAddr_r <= MADDR_RST;
        end else begin
            state_r   <= state_nxt;
            cmd_r     <= cmd_nxt;
            acc_r     <= acc_nxt;
            flags_r   <= flags_nxt;
            pc_r      <= pc_nxt;
            memAddr_r <= memAddr_nxt;
        end
    end

    // Bus answer and last-instruction status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r    <= 1'b0;
            idleQ_r  <= 1'b0;
            datO_r   <= '0;
            skip_r   <= 1'b0;
            twoCyc_r <= 1'b0;
        end else begin
            ack_r   <= grant;
            idleQ_r <= idle;
            if (grant) begin
                datO_r <= rdMux;
            end
            if (inExec) begin
                skip_r   <= exSkip;
                twoCyc_r <= exSkip | exExit;
            end
        end
    end

    ies_return_stack #(
        .W     (PC_W),
        .DEPTH (STACK_DEPTH)
    ) u_stack (
        .clk      (clk),
        .rst_b    (rst_b),
        .push     (wrTake & hitPush & sel_i[0]),
        .pushData (dat_i[PC_W-1:0]),
        .pop      (exPop),
        .top      (stackTop),
        .empty    (stackEmpty),
        .full     (stackFull),
        .depth    (stackDepth)
    );

    ies_data_ram #(
        .AW (DATA_AW),
        .DW (8)
    ) u_ram (
        .clk    (clk),
        .rst_b  (rst_b),
        .wrEn   (memWrEn),
        .wrAddr (memWrAddr),
        .wrData (inExec ? exRes : dat_i[7:0]),
        .rdAddr (memRdAddr),
        .rdData (memQ)
    );

    assign ack_o    = ack_r;
    assign dat_o    = datO_r;
    assign flagsOut = flags_r;
    assign pcOut    = pc_r;
    assign busy     = ~idle;

endmodule

`default_nettype wire

//--- ies_exec_unit_props.sv
// Port checker for the execute unit.
// Assumes it is bound to every ies_exec_unit instance.
`default_nettype none

module ies_exec_unit_chk #(
    parameter int PC_W = 12
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // Bus
    input wire logic                we_i,
    input wire logic [7:0]          adr_i,
    input wire logic [31:0]         dat_i,
    input wire logic                ack_o,
    // Core side
    input wire ies_pkg::ies_flags_s flagsOut,
    input wire logic [PC_W-1:0]     pcOut,
    input wire logic                busy
);
    import ies_pkg::*;

    wire logic       cmdWr   = ack_o && we_i && adr_i == REG_CMD;
    wire logic       flagsWr = ack_o && we_i && adr_i == REG_FLAGS;
    wire logic [4:0] op      = dat_i[4:0];
    wire logic       opRun   = op >= 5'h01 && op <= 5'h15;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_cmd(logic [4:0] code);
        cmdWr && op == code;
    endsequence
    // Exits and taken skips both end with one dummy cycle
    sequence s_dummy;
        busy ##1 !busy;
    endsequence

    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held too long");
    property p_busy_start;
        cmdWr && opRun |=> busy;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("command did not start");
    property p_busy_bound;
        busy |-> ##[1:3] !busy;
    endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("instruction too long");
    property p_ret_two;
        s_cmd(OP_SUBROUTINE_EXIT) |-> ##3 s_dummy;
    endproperty
    a_ret_two: assert property (p_ret_two)
        else $error("exit not two cycles");
    property p_ret_flags;
        s_cmd(OP_SUBROUTINE_EXIT) |-> ##4 flagsOut == $past(flagsOut, 4);
    endproperty
    a_ret_flags: assert property (p_ret_flags)
        else $error("exit changed flags");
    property p_set_byte;
        s_cmd(OP_SET_BYTE) |-> ##3 pcOut - $past(pcOut, 3) == PC_W'(1)
            && flagsOut == $past(flagsOut, 3);
    endproperty
    a_set_byte: assert property (p_set_byte)
        else $error("byte set changed flags or pc step");
    property p_skip_len;
        s_cmd(OP_SKIP_BIT_NONZERO)
            |-> ##3 busy == (pcOut - $past(pcOut, 3) == PC_W'(2));
    endproperty
    a_skip_len: assert property (p_skip_len)
        else $error("skip length and pc step disagree");
    property p_iexit_gie;
        s_cmd(OP_INTERRUPT_EXIT) |-> ##4 flagsOut.gie;
    endproperty
    a_iexit_gie: assert property (p_iexit_gie)
        else $error("interrupt exit left enable low");
    property p_gie_hold;
        flagsOut.gie && !flagsWr |=> flagsOut.gie;
    endproperty
    a_gie_hold: assert property (p_gie_hold)
        else $error("enable cleared by hardware");
    property p_rot_flags;
        s_cmd(OP_ROTATE_LEFT_MEM) |-> ##3 flagsOut == $past(flagsOut, 3);
    endproperty
    a_rot_flags: assert property (p_rot_flags)
        else $error("rotate changed flags");
endmodule

bind ies_exec_unit ies_exec_unit_chk #(.PC_W(PC_W)) u_chk (
    .clk(clk), .rst_b(rst_b), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
    .ack_o(ack_o), .flagsOut(flagsOut), .pcOut(pcOut), .busy(busy));

`default_nettype wire

//--- testbench.sv
// Self-checking bench for the execute unit with an integer model.
// Assumes the unit answers every bus request in bounded time.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ies_pkg::*;

    logic        clk   = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h0;
    logic [3:0]  sel   = 4'h0;
    logic        ack;
    logic        bsy;
    logic [31:0] dout;
    logic [31:0] rdv;
    logic [11:0] pc;
    ies_flags_s  fl;
    int          numErrors = 0;
    int          nCompared = 0;
    int          cycles    = 0;
    int          seed      = 32'h403E7508;
    int          stk[$];
    int          a, m, f, p, op, b, imm, r, s, sk, two, cy, hc, c7;

    ies_exec_unit u_dut (.clk(clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .ack_o(ack),
        .dat_o(dout), .flagsOut(fl), .pcOut(pc), .busy(bsy));

    always #2 clk = ~clk;

    // Hang guard, far above the few thousand cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            numErrors = numErrors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (numErrors == 0 && nCompared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; ack and read data are taken at
    // the rising edge where ack is sampled high, then the request drops
    task automatic wb(input logic w, input logic [7:0] ad, input int d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        dat <= d;
        sel <= 4'hF;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rdv = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdc(input logic [7:0] ad, input int e);
        wb(1'b0, ad, 0);
        chk(rdv, e);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rdc(REG_ACC, ACC_RST);
        rdc(REG_FLAGS, FLAGS_RST);
        rdc(REG_STATUS, 1 << STS_EMPTY);
        rdc(8'h20, 0);
        for (int i = 0; i < 84; i++) begin
            op = i % 21 + 1;
            a = $random(seed) & 255;
            m = $random(seed) & 255;
            if (i < 63)
                m = i < 21 ? 1 : i < 42 ? 255 : 0;
            f = $random(seed) & 31;
            p = $random(seed) & 4095;
            b = $random(seed) & 7;
            imm = $random(seed) & 255;
            r = $random(seed) & 4095;
            wb(1'b1, REG_FLAGS, f);
            wb(1'b1, REG_ACC, a);
            wb(1'b1, REG_MADDR, i);
            wb(1'b1, REG_MDATA, m);
            wb(1'b1, REG_PC, p);
            wb(1'b1, REG_PUSH, r);
            if (stk.size() < 16)
                stk.push_back(r);
            wb(1'b1, REG_CMD, {imm[7:0], i[7:0], b[2:0], op[4:0]});
            chk({31'h0, bsy}, 1);
            sk = 0;
            two = 0;
            s = a + (~m & 255) + (f & 1);
            case (op)
                1: begin
                    m = a | m;
                    f = f & 27 | (m == 0) << 2;
                end
                2, 3, 4: begin
                    p = stk.size() ? stk.pop_back() : 0;
                    if (op == 3)
                        a = imm;
                    if (op == 4)
                        f = f | 16;
                    two = 1;
                end
                5, 6: r = {m[6:0], m[7]};
                7, 8: begin
                    r = {m[6:0], f[0]};
                    f = f & 30 | m[7];
                end
                9, 10: r = {m[0], m[7:1]};
                11, 12: begin
                    r = {f[0], m[7:1]};
                    f = f & 30 | m[0];
                end
                13, 14: begin
                    r = s & 255;
                    cy = s >> 8;
                    hc = ((a & 15) + (~m & 15) + (f & 1)) >> 4;
                    c7 = ((a & 127) + (~m & 127) + (f & 1)) >> 7;
                    f = f & 16 | (c7 ^ cy) << 3 | (r == 0) << 2 | hc << 1 | cy;
                    if (op == 13)
                        a = r;
                    else
                        m = r;
                end
                15, 16, 19, 20: begin
                    r = (op < 19 ? m - 1 : m + 1) & 255;
                    sk = r == 0;
                    if (op % 2)
                        m = r;
                    else
                        a = r;
                end
                17: m = 255;
                18: m = m | 1 << b;
                default: sk = m >> b & 1;
            endcase
            if (op >= 5 && op <= 12) begin
                if (op % 2)
                    m = r;
                else
                    a = r;
            end
            if (!two)
                p = (p + 1 + sk) & 4095;
            two = two | sk;
            // Misaligned write must be ignored
            wb(1'b1, 8'h05, $random(seed));
            rdc(REG_ACC, a);
            rdc(REG_FLAGS, f);
            rdc(REG_PC, p);
            rdc(REG_MDATA, m);
            rdc(REG_STATUS, (stk.size() == 16) << 4 | (stk.size() == 0) << 3
                | two << 2 | sk << 1);
            rdc(REG_PUSH, stk.size());
            chk({27'h0, fl}, f);
            chk({20'h0, pc}, p);
        end
        end_of_test();
    end
endmodule

`default_nettype wire
